// *** verilog/subret_consts.vh ***
// Constants for the subroutine-return decode and execute block.
// Assumes a core that issues one instruction word per four-phase instruction cycle.
//
// Functional notes
// RULE_01: Upper byte 0000 1100 returns with literal; low byte written into working register.
// RULE_02: Return-with-literal pops the return stack and loads top of stack into PC.
// RULE_03: Neither return touches the PC upper latch or PC high latch.
// RULE_04: Plain subroutine return pops the stack and loads top of stack into PC.
// RULE_05: Fast flag set copies working, status, bank-select shadows into live registers.
// RULE_06: Fast flag clear leaves working, status and bank-select registers unaltered.
// RULE_07: Return decodes 0000 0000 0001 001x; one word, two cycles, second a flush.
`ifndef SUBRET_CONSTS_VH
`define SUBRET_CONSTS_VH
`define OPC_LIT_HI 8'h0c
`define OPC_RET_HI 15'h0009
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3
`define ST_EXEC 1'h0
`define ST_FLUSH 1'h1
`endif

// *** verilog/ret_decoder.v ***
// Combinational decoder that classifies one instruction word as a return.
// Assumes the word is stable while it is examined.
`timescale 1ns/1ps
`include "subret_consts.vh"
module ret_decoder (
    input wire [15:0] instr,
    output wire is_lit,
    output wire is_ret,
    output wire fast,
    output wire [7:0] literal
);
    assign is_lit = (instr[15:8] == `OPC_LIT_HI); // [RULE_01]
    assign is_ret = (instr[15:1] == `OPC_RET_HI); // [RULE_07]
    assign fast = instr[0];
    assign literal = instr[7:0];
endmodule

// *** verilog/subroutine_return_decode.v ***
// Execute logic for the two subroutine-return instructions.
// Assumes the core supplies the quarter-cycle phase and keeps the stack top valid.
`timescale 1ns/1ps
`include "subret_consts.vh"
module subroutine_return_decode #(
    parameter PC_W = 21
) (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire [1:0] phase,
    input wire [15:0] instr,
    input wire [PC_W-1:0] top_of_stack,
    input wire [7:0] working_shadow,
    input wire [7:0] status_shadow,
    input wire [7:0] bank_select_shadow,
    input wire [7:0] working_in,
    input wire [7:0] status_in,
    input wire [7:0] bank_select_in,
    output reg stack_pop_q,
    output reg pc_load_q,
    output reg [PC_W-1:0] pc_value_q,
    output reg w_we_q,
    output reg [7:0] working_q,
    output reg status_we_q,
    output reg [7:0] status_q,
    output reg bsr_we_q,
    output reg [7:0] bank_select_register_q,
    output reg pclat_we_q,
    output reg flush_q
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire is_lit;
    wire is_ret;
    wire fast;
    wire [7:0] literal;
    reg st_q;
    reg [7:0] lit_q;
    reg ret_q;
    reg litop_q;
    reg fast_q;

    ret_decoder u_dec (
        .instr(instr),
        .is_lit(is_lit),
        .is_ret(is_ret),
        .fast(fast),
        .literal(literal)
    );

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    // Strobes are one clock wide, raised on the Q4 edge; the core samples them at Q1.
    always @(posedge clk) begin
        if (sys_rst) begin
            st_q <= `ST_EXEC;
            lit_q <= 8'h00;
            ret_q <= 1'b0;
            litop_q <= 1'b0;
            fast_q <= 1'b0;
            stack_pop_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_value_q <= {PC_W{1'b0}};
            w_we_q <= 1'b0;
            working_q <= 8'h00;
            status_we_q <= 1'b0;
            status_q <= 8'h00;
            bsr_we_q <= 1'b0;
            bank_select_register_q <= 8'h00;
            pclat_we_q <= 1'b0;
            flush_q <= 1'b0;
        end else if (ce) begin
            stack_pop_q <= 1'b0;
            pc_load_q <= 1'b0;
            w_we_q <= 1'b0;
            status_we_q <= 1'b0;
            bsr_we_q <= 1'b0;
            pclat_we_q <= 1'b0; // [RULE_03]
            case (st_q)
                `ST_EXEC: begin
                    flush_q <= 1'b0;
                    if (phase == `PH_Q1) begin
                        litop_q <= is_lit;
                        ret_q <= is_ret;
                        fast_q <= fast;
                        lit_q <= literal;
                    end else if (phase == `PH_Q4 && (litop_q || ret_q)) begin
                        stack_pop_q <= 1'b1; // [RULE_02] [RULE_04]
                        pc_load_q <= 1'b1;
                        pc_value_q <= top_of_stack;
                        st_q <= `ST_FLUSH; // [RULE_07]
                        if (litop_q) begin
                            w_we_q <= 1'b1;
                            working_q <= lit_q; // [RULE_01]
                        end else if (fast_q) begin
                            w_we_q <= 1'b1; // [RULE_05]
                            working_q <= working_shadow;
                            status_we_q <= 1'b1;
                            status_q <= status_shadow;
                            bsr_we_q <= 1'b1;
                            bank_select_register_q <= bank_select_shadow;
                        end else begin
                            working_q <= working_in; // [RULE_06]
                            status_q <= status_in;
                            bank_select_register_q <= bank_select_in;
                        end
                    end
                end
                `ST_FLUSH: begin
                    // The prefetched word is discarded for the whole cycle.
                    flush_q <= 1'b1; // [RULE_07]
                    litop_q <= 1'b0;
                    ret_q <= 1'b0;
                    if (phase == `PH_Q4) begin
                        st_q <= `ST_EXEC;
                    end
                end
                default: st_q <= `ST_EXEC;
            endcase
        end
    end
endmodule

// *** verification/subret_monitor.sv ***
// Checker for the return decode block, bound to its top module ports.
// Assumes phase steps once per clock and ce stays high.
`timescale 1ns/1ps
module subret_monitor #(parameter PC_W = 21) (
    input wire clk, input wire sys_rst, input wire [15:0] instr,
    input wire [PC_W-1:0] top_of_stack, input wire [7:0] status_shadow,
    input wire stack_pop_q, input wire pc_load_q, input wire [PC_W-1:0] pc_value_q,
    input wire w_we_q, input wire [7:0] working_q, input wire status_we_q,
    input wire [7:0] status_q, input wire bsr_we_q, input wire pclat_we_q, input wire flush_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_lit_data: assert property (w_we_q && $past(instr[15:8], 4) == 8'h0c |->
        working_q == $past(instr[7:0], 4)) else $error("literal not written");
    chk_pop_load: assert property (stack_pop_q |->
        pc_load_q && pc_value_q == $past(top_of_stack)) else $error("pc not loaded");
    chk_latch_kept: assert property (!pclat_we_q) else $error("latch written");
    chk_fast_copy: assert property (w_we_q && $past(instr[15:1], 4) == 15'h0009 |->
        status_we_q && bsr_we_q && status_q == $past(status_shadow)) else $error("no restore");
    chk_slow_keep: assert property (stack_pop_q && $past(instr, 4) == 16'h0012 |->
        !(w_we_q || status_we_q || bsr_we_q)) else $error("slow return wrote");
    chk_flush_span: assert property (stack_pop_q |=> flush_q [*4] ##1 !flush_q)
        else $error("flush span wrong");
    chk_pop_cause: assert property (stack_pop_q |-> $past(instr[15:8], 4) == 8'h0c ||
        $past(instr[15:1], 4) == 15'h0009) else $error("pop without return");
    chk_pop_once: assert property (stack_pop_q |=> !stack_pop_q [*3])
        else $error("pop repeated");
endmodule
bind subroutine_return_decode subret_monitor #(.PC_W(PC_W)) mon (.*);

// *** verification/subroutine_return_decode_bench.sv ***
// Self-checking bench for the return decode block.
// Assumes the bench supplies phase and holds ce high.
`timescale 1ns/1ps
module subroutine_return_decode_bench;
    logic clk = 0, sys_rst = 1, ce = 1;
    logic [1:0] phase = 0;
    logic [15:0] instr = 0;
    logic [20:0] top_of_stack = 0, pc_value_q;
    logic [7:0] working_shadow = 8'ha5, status_shadow = 8'h3c, bank_select_shadow = 8'h0f;
    logic [7:0] working_in = 8'h5a, status_in = 8'hc3, bank_select_in = 8'h77;
    logic stack_pop_q, pc_load_q, w_we_q, status_we_q, bsr_we_q, pclat_we_q, flush_q;
    logic [7:0] working_q, status_q, bank_select_register_q;
    int fails = 0, n_compared = 0;
    logic [25:0] rows [0:5] = '{{16'h0c00, 10'h300}, {16'h0cff, 10'h3ff},
        {16'h0013, 10'h3a5}, {16'h0012, 10'h25a}, {16'h0011, 10'h000}, {16'h0d55, 10'h000}};
    subroutine_return_decode dut (.*);
    initial forever #5 clk = ~clk;
    always @(posedge clk) phase <= #1 phase + 2'h1;
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task exec(input logic [15:0] i);
        do @(posedge clk); while (phase !== 2'h3);
        #1 instr = i;
        top_of_stack = {5'h1f, i};
        repeat (4) @(posedge clk);
        #2;
    endtask
    initial begin
        #5000;
        fails++;
        close_out;
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 sys_rst = 0;
        chk(stack_pop_q, 0, "pop after reset");
        for (int k = 0; k < 6; k++) begin
            exec(rows[k][25:10]);
            chk(stack_pop_q, rows[k][9], "pop");
            chk(w_we_q, rows[k][8], "w_we");
            chk(pclat_we_q, 0, "pclat");
            chk(pc_load_q, rows[k][9], "pc_load");
            chk(status_we_q, rows[k][25:10] == 16'h0013, "status_we");
            chk(bsr_we_q, rows[k][25:10] == 16'h0013, "bsr_we");
            chk(flush_q, 0, "flush before");
            if (rows[k][25:11] == 15'h0009) begin
                chk(status_q, rows[k][10] ? 8'h3c : 8'hc3, "status");
                chk(bank_select_register_q, rows[k][10] ? 8'h0f : 8'h77, "bsr");
            end
            if (rows[k][9]) begin
                chk(working_q, rows[k][7:0], "working");
                chk(pc_value_q, top_of_stack, "pc");
                @(posedge clk);
                #2 chk(flush_q, 1, "flush");
            end
        end
        // A return offered in the flush cycle must be ignored.
        exec(16'h0c42);
        instr = 16'h0c99;
        repeat (4) @(posedge clk);
        #2 chk(stack_pop_q, 0, "flush pop");
        chk(working_q, 8'h42, "kept");
        chk(flush_q, 1, "flush held");
        instr = 16'h0000;
        @(posedge clk);
        #2 chk(flush_q, 0, "flush end");
        chk(stack_pop_q, 0, "no late pop");
        close_out;
    end
endmodule
